// ---- rtl/pfps_top.sv ----
// Function
// - Upper power field bit selects auxiliary supply
// - Power register bits 7 to 2 read zero
// - Power and input selection register families
// - Chip-select source: 01 A3, 10 A2, 11 A3
// - Periodic capture source: B2 or B4
// - Standard capture source: E2 or E3
// - Input select bits 7,6 zero; reset zero
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module pfps_top #(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pfps_pkg::pfps_pins_t pins_async,
  output pfps_pkg::pfps_periph_t periph,
  output logic port_f_aux_supply_sel,
  output logic [7:0] input_source_select_n
);

  // The decode compares against 12-bit offsets
  if (ADDR_W < 12) begin : g_addr_w_check
    $error("ADDR_W must be at least 12");
  end

  logic [7:0] port_f_power_source_select_ff;
  logic [7:0] input_source_select_0_ff;
  logic [7:0] nxt_power;
  logic [7:0] nxt_input;
  logic wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  pfps_pkg::pfps_pins_t pins_meta_ff;
  pfps_pkg::pfps_pins_t pins_sync_ff;

  wire logic addr_phase;
  wire logic rd_req;
  wire logic wr_power;
  wire logic wr_input;
  wire logic [ADDR_W-1:0] addr_word;

  // Two-stage synchroniser on pin inputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pins_meta_ff <= '0;
      pins_sync_ff <= '0;
    end else if (clk_en) begin
      pins_meta_ff <= pins_async;
      pins_sync_ff <= pins_meta_ff;
    end
  end

  assign addr_phase = hsel && hready && (htrans == pfps_pkg::HTRANS_NONSEQ);
  assign rd_req = addr_phase && !hwrite;
  assign addr_word = {haddr[ADDR_W-1:2], 2'b00};
  assign wr_power = wr_pend_ff && (wr_addr_ff == ADDR_W'(pfps_pkg::ADDR_POWER_SOURCE));
  assign wr_input = wr_pend_ff && (wr_addr_ff == ADDR_W'(pfps_pkg::ADDR_INPUT_SELECT_0));

  // Unimplemented bits masked on write so they always read zero
  assign nxt_power = wr_power ? (hwdata[7:0] & pfps_pkg::POWER_SOURCE_MASK) :
    port_f_power_source_select_ff;
  assign nxt_input = wr_input ? (hwdata[7:0] & pfps_pkg::INPUT_SELECT_MASK) :
    input_source_select_0_ff;

  // Read data forwards a write landing at the same edge
  assign nxt_hrdata =
    !rd_req ? 32'h0000_0000 :
    (addr_word == ADDR_W'(pfps_pkg::ADDR_POWER_SOURCE)) ?
      {24'h00_0000, nxt_power} :
    (addr_word == ADDR_W'(pfps_pkg::ADDR_INPUT_SELECT_0)) ?
      {24'h00_0000, nxt_input} :
    32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata_ff <= 32'h0000_0000;
      port_f_power_source_select_ff <= pfps_pkg::POWER_SOURCE_RESET;
      input_source_select_0_ff <= pfps_pkg::INPUT_SELECT_RESET;
    end else if (clk_en) begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= addr_word;
      hrdata_ff <= nxt_hrdata;
      port_f_power_source_select_ff <= nxt_power;
      input_source_select_0_ff <= nxt_input;
    end
  end

  // Zero wait states; unmapped addresses read zero and ignore writes
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Software must have set the supply pin function beforehand
  assign port_f_aux_supply_sel =
    port_f_power_source_select_ff[pfps_pkg::POWER_AUX_BIT];
  assign input_source_select_n = input_source_select_0_ff;

  pfps_input_route u_route (
    .input_source_select_0(input_source_select_0_ff),
    .pins(pins_sync_ff),
    .periph(periph)
  );

endmodule

`default_nettype wire

// ---- rtl/pfps_pkg.sv ----
package pfps_pkg;

  // Word byte addresses on the register bus
  localparam logic [11:0] ADDR_POWER_SOURCE = 12'h000;
  localparam logic [11:0] ADDR_INPUT_SELECT_0 = 12'h004;

  localparam logic [7:0] POWER_SOURCE_RESET = 8'h00;
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] POWER_SOURCE_MASK = 8'h03;
  localparam logic [7:0] INPUT_SELECT_MASK = 8'h3f;

  localparam int POWER_AUX_BIT = 1;
  localparam int CS_FIELD_LSB = 4;
  localparam int PTP_FIELD_LSB = 2;
  localparam int STP_FIELD_LSB = 0;

  localparam logic [1:0] CS_CODE_NONE = 2'h0;
  localparam logic [1:0] CS_CODE_A2 = 2'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic port_a_bit_two;
    logic port_a_bit_three;
    logic port_b_bit_two;
    logic port_b_bit_four;
    logic port_e_bit_two;
    logic port_e_bit_three;
  } pfps_pins_t;

  typedef struct packed {
    logic serial_chip_select_in;
    logic serial_chip_select_valid;
    logic periodic_timer_capture_in;
    logic standard_timer_capture_in;
  } pfps_periph_t;

endpackage

// ---- rtl/pfps_input_route.sv ----
`timescale 1ns/100ps
`default_nettype none

// Pure mux from pin inputs to peripheral inputs
module pfps_input_route (
  input wire logic [7:0] input_source_select_0,
  input wire pfps_pkg::pfps_pins_t pins,
  output pfps_pkg::pfps_periph_t periph
);

  wire logic [1:0] chip_select_source_field;
  wire logic [1:0] periodic_capture_source_field;
  wire logic [1:0] standard_capture_source_field;

  assign chip_select_source_field =
    input_source_select_0[pfps_pkg::CS_FIELD_LSB +: 2];
  assign periodic_capture_source_field =
    input_source_select_0[pfps_pkg::PTP_FIELD_LSB +: 2];
  assign standard_capture_source_field =
    input_source_select_0[pfps_pkg::STP_FIELD_LSB +: 2];

  // Code 00 has no source: input held low and flagged invalid
  assign periph.serial_chip_select_valid =
    (chip_select_source_field != pfps_pkg::CS_CODE_NONE);
  assign periph.serial_chip_select_in =
    (chip_select_source_field == pfps_pkg::CS_CODE_NONE) ? 1'b0 :
    (chip_select_source_field == pfps_pkg::CS_CODE_A2) ? pins.port_a_bit_two :
    pins.port_a_bit_three;
  // Only the low field bit matters
  assign periph.periodic_timer_capture_in = periodic_capture_source_field[0] ?
    pins.port_b_bit_four : pins.port_b_bit_two;
  assign periph.standard_timer_capture_in = standard_capture_source_field[0] ?
    pins.port_e_bit_three : pins.port_e_bit_two;

endmodule

`default_nettype wire

// ---- verif/pfps_pins_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfps_pins_model (
  input wire logic core_clk,
  output var pfps_pkg::pfps_pins_t pins
);
  int seed = 98;
  int k = 0;
  initial pins = '0;
  // Pins only ever act as inputs of the block here
  always @(posedge core_clk) begin
    k <= k + 1;
    if (k % 5 == 0) pins <= pfps_pkg::pfps_pins_t'(6'($random(seed)));
  end
endmodule
`default_nettype wire

// ---- verif/pfps_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfps_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire pfps_pkg::pfps_pins_t pins_async,
  input wire pfps_pkg::pfps_periph_t periph,
  input wire logic port_f_aux_supply_sel,
  input wire logic [7:0] input_source_select_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] s = input_source_select_n;
  wire logic wr = hsel && hready && htrans == pfps_pkg::HTRANS_NONSEQ && hwrite;
  // Pins and select settled long enough to pass the synchroniser
  sequence calm;
    $stable(pins_async) && $stable(s) && $past(pins_async, 2) == pins_async
      && $past(rst_b) && $past(rst_b, 2);
  endsequence
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response");
  a_aux_write: assert property (
    wr && haddr == pfps_pkg::ADDR_POWER_SOURCE ##1 1'b1 |=>
      port_f_aux_supply_sel == $past(hwdata[1])) else $error("aux supply");
  a_sel_write: assert property (
    wr && haddr == pfps_pkg::ADDR_INPUT_SELECT_0 ##1 1'b1 |=>
      s == ($past(hwdata[7:0]) & pfps_pkg::INPUT_SELECT_MASK)) else $error("select");
  a_sel_upper: assert property (s[7:6] == 2'h0) else $error("upper bits");
  a_cs_valid: assert property (
    calm |-> periph.serial_chip_select_valid == (s[5:4] != pfps_pkg::CS_CODE_NONE))
    else $error("cs valid");
  a_cs_route: assert property (calm |-> periph.serial_chip_select_in ==
    ((s[5:4] == pfps_pkg::CS_CODE_NONE) ? 1'b0 : (s[5:4] == pfps_pkg::CS_CODE_A2) ?
      pins_async.port_a_bit_two : pins_async.port_a_bit_three)) else $error("cs");
  a_ptp_route: assert property (calm |-> periph.periodic_timer_capture_in ==
    (s[2] ? pins_async.port_b_bit_four : pins_async.port_b_bit_two)) else $error("ptp");
  a_stp_route: assert property (calm |-> periph.standard_timer_capture_in ==
    (s[0] ? pins_async.port_e_bit_three : pins_async.port_e_bit_two)) else $error("stp");
endmodule
`default_nettype wire

// ---- verif/pfps_top_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfps_top_tb_top;
  logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [11:0] haddr = '0, a;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0, hrdata, r, d;
  logic hreadyout, hresp, port_f_aux_supply_sel;
  logic [7:0] input_source_select_n, p, i;
  pfps_pkg::pfps_pins_t pins_async, ph1, ph2;
  pfps_pkg::pfps_periph_t periph;
  logic [11:0] a_tab [3] = '{pfps_pkg::ADDR_POWER_SOURCE, pfps_pkg::ADDR_INPUT_SELECT_0, 12'h008};
  int n_fail = 0, tests_run = 0, seed = 98;
  wire logic hready = hreadyout;
  always #12.5 core_clk = ~core_clk;
  // Pin history matching the two-stage synchroniser delay
  always @(negedge core_clk) begin
    ph1 <= pins_async;
    ph2 <= ph1;
  end
  pfps_pins_model pfps_pins_model_i (.core_clk, .pins(pins_async));
  pfps_top pfps_top_i (.core_clk, .rst_b, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pins_async, .periph,
    .port_f_aux_supply_sel, .input_source_select_n);
  function logic [31:0] exp_rd(logic [11:0] ad, logic [7:0] pw, logic [7:0] sl);
    return (ad == a_tab[0]) ? {24'h0, pw & 8'h03} : (ad == a_tab[1]) ? {24'h0, sl & 8'h3f} : '0;
  endfunction
  function logic [3:0] exp_route(logic [7:0] sl, pfps_pkg::pfps_pins_t pn);
    logic cs;
    cs = (sl[5:4] == 2'h2) ? pn.port_a_bit_two : pn.port_a_bit_three;
    return {(sl[5:4] != 2'h0) && cs, sl[5:4] != 2'h0,
      sl[2] ? pn.port_b_bit_four : pn.port_b_bit_two,
      sl[0] ? pn.port_e_bit_three : pn.port_e_bit_two};
  endfunction
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge core_clk);
    while (hready !== 1'b1 && k < 99) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 99) begin
      n_fail++;
      give_verdict;
    end
  endtask
  task xfer(input logic [11:0] ad, input logic w, input logic [31:0] wd);
    haddr <= ad;
    htrans <= pfps_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= pfps_pkg::HSIZE_WORD;
    rdy;
    htrans <= '0;
    hwdata <= wd;
    rdy;
    r = hrdata;
    @(posedge core_clk);
  endtask
  initial begin
    p = '0;
    i = '0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      if (n == 12) begin
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        p = '0;
        i = '0;
      end
      foreach (a_tab[j]) begin
        xfer(a_tab[j], 1'b0, '0);
        chk(r, exp_rd(a_tab[j], p, i));
      end
      chk({port_f_aux_supply_sel, input_source_select_n}, {p[1], i & 8'h3f});
      @(negedge core_clk);
      chk(periph, exp_route(i & 8'h3f, ph2));
      @(posedge core_clk);
      // Every code in every field first, with the unused upper bits set
      d = (n < 4) ? {26'h3ffffff, {3{n[1:0]}}} : $random(seed);
      a = (n < 4) ? a_tab[1] : a_tab[n % 3];
      xfer(a, 1'b1, d);
      if (a == a_tab[0]) p = d[7:0];
      if (a == a_tab[1]) i = d[7:0];
    end
    give_verdict;
  end
endmodule
bind pfps_top pfps_assertions #(.ADDR_W(ADDR_W)) pfps_assertions_i (.core_clk, .rst_b, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pins_async, .periph,
  .port_f_aux_supply_sel, .input_source_select_n);
`default_nettype wire
